// >>> damp_cfg_pkg.sv
package damp_cfg_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [6:0] AUX_DAMP_ADDR     = 7'h6A;
    localparam logic [6:0] MAIN_DAMP_ADDR    = 7'h6B;
    localparam logic [7:0] AUX_DAMP_RESET    = 8'h13;
    localparam logic [7:0] MAIN_DAMP_RESET   = 8'h13;
    localparam logic [7:0] DAMP_WRITE_MASK   = 8'h77;
    localparam int         GAIN_LSB          = 4;
    localparam int         GAIN_MSB          = 6;
    localparam int         CODE_LSB          = 0;
    localparam int         CODE_MSB          = 2;

    // ****************************************************************
    // Serial port framing
    // ****************************************************************
    localparam int         CMD_RW_BIT        = 7;
    localparam logic [2:0] LAST_BIT          = 3'h7;

    // ****************************************************************
    // Bandwidth classes and damping factors
    // ****************************************************************
    localparam logic [2:0] BW_4HZ            = 3'h0;
    localparam logic [2:0] BW_8HZ            = 3'h1;
    localparam logic [2:0] BW_18HZ           = 3'h2;
    localparam logic [2:0] BW_35HZ           = 3'h3;
    localparam logic [2:0] BW_70HZ           = 3'h4;

    localparam logic [2:0] DF_1P2            = 3'h0;
    localparam logic [2:0] DF_2P5            = 3'h1;
    localparam logic [2:0] DF_5              = 3'h2;
    localparam logic [2:0] DF_10             = 3'h3;
    localparam logic [2:0] DF_20             = 3'h4;
    localparam logic [2:0] DF_NONE           = 3'h7;

    typedef enum logic [3:0] {
        SP_IDLE = 4'h1,
        SP_CMD  = 4'h2,
        SP_DATA = 4'h4,
        SP_DONE = 4'h8
    } spi_state_t;

endpackage

// >>> damp_cfg.sv
// Functional notes
// - Bits 6 to 4 of each damping register hold the low-frequency gain used at 8 kHz or below in analog feedback.
// - That gain only applies while the loop's secondary detector gain enable is set.
// - Above 8 kHz in analog feedback the loop uses the high-frequency gain field instead.
// - Auxiliary bits 2 to 0 pick a bandwidth-dependent damping factor, code 011 being 5.
// - The main loop damping register resets to 0x13.
// - Main damping codes resolve to factors per bandwidth class 4, 8, 18, 35 or 70 Hz.
`timescale 1ns/1ps
module damp_cfg
    import damp_cfg_pkg::*;
(
    input  wire logic       I_CLK,
    input  wire logic       I_SYS_RST,
    input  wire logic       I_SPI_CS_N,
    input  wire logic       I_SPI_SCLK,
    input  wire logic       I_SPI_SDI,
    output logic            O_SPI_SDO,
    output logic            O_SPI_SDO_OE,
    input  wire logic [2:0] I_MAIN_BW_CLASS,
    input  wire logic [2:0] I_AUX_BW_CLASS,
    input  wire logic       I_MAIN_GAIN_ON,
    input  wire logic       I_AUX_GAIN_ON,
    input  wire logic [2:0] I_MAIN_HF_GAIN,
    input  wire logic [2:0] I_AUX_HF_GAIN,
    input  wire logic       I_MAIN_ANALOG,
    input  wire logic       I_AUX_ANALOG,
    input  wire logic       I_MAIN_REF_LE_8K,
    input  wire logic       I_AUX_REF_LE_8K,
    output logic [2:0]      O_MAIN_DAMP_FACTOR,
    output logic [2:0]      O_AUX_DAMP_FACTOR,
    output logic            O_MAIN_SPD_USED,
    output logic            O_AUX_SPD_USED,
    output logic [2:0]      O_MAIN_SPD_GAIN,
    output logic [2:0]      O_AUX_SPD_GAIN
);

    // ****************************************************************
    // Lookup functions
    // ****************************************************************
    function automatic logic [2:0] damp_factor(input logic [2:0] code, input logic [2:0] bw);
        logic [2:0] f;
        f = DF_NONE;
        case (code)
            3'h1: begin
                f = (bw == BW_4HZ) ? DF_5 : (bw == BW_8HZ) ? DF_2P5 : DF_1P2;
            end
            3'h2: begin
                f = (bw == BW_4HZ || bw == BW_8HZ) ? DF_5 : DF_2P5;
            end
            3'h3: begin
                f = DF_5;
            end
            3'h4: begin
                f = (bw == BW_4HZ) ? DF_5 : DF_10;
            end
            3'h5: begin
                f = (bw == BW_4HZ) ? DF_5 : (bw == BW_8HZ) ? DF_10 : DF_20;
            end
            default: begin
                f = DF_NONE;
            end
        endcase
        if (bw > BW_70HZ) begin
            f = DF_NONE;
        end
        return f;
    endfunction

    function automatic logic [2:0] spd_gain(input logic analog, input logic le_8k,
                                             input logic [2:0] lf, input logic [2:0] hf);
        logic [2:0] g;
        g = hf;
        if (analog && le_8k) begin
            g = lf;
        end
        return g;
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [1:0] cs_sync_r;
    logic [2:0] sclk_sync_r;
    logic [1:0] sdi_sync_r;
    logic       cs_active;
    logic       sclk_rise;

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            cs_sync_r   <= 2'h3;
            sclk_sync_r <= 3'h0;
            sdi_sync_r  <= 2'h0;
        end else begin
            cs_sync_r   <= {cs_sync_r[0], I_SPI_CS_N};
            sclk_sync_r <= {sclk_sync_r[1:0], I_SPI_SCLK};
            sdi_sync_r  <= {sdi_sync_r[0], I_SPI_SDI};
        end
    end

    assign cs_active = ~cs_sync_r[1];
    assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];

    // ****************************************************************
    // Serial port and register bank
    // ****************************************************************
    spi_state_t state_r, state_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic [7:0] aux_r, aux_nxt;
    logic [7:0] main_r, main_nxt;
    logic       oe_nxt;
    logic [7:0] shift_in;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        rx_nxt    = rx_r;
        cmd_nxt   = cmd_r;
        tx_nxt    = tx_r;
        aux_nxt   = aux_r;
        main_nxt  = main_r;
        shift_in  = {rx_r[6:0], sdi_sync_r[1]};
        if (!cs_active) begin
            state_nxt = SP_IDLE;
            cnt_nxt   = 3'h0;
        end else begin
            case (state_r)
                SP_IDLE: begin
                    state_nxt = SP_CMD;
                    cnt_nxt   = 3'h0;
                end
                SP_CMD: begin
                    if (sclk_rise) begin
                        rx_nxt  = shift_in;
                        cnt_nxt = cnt_r + 3'h1;
                        if (cnt_r == LAST_BIT) begin
                            cmd_nxt   = shift_in;
                            state_nxt = SP_DATA;
                            // Unmapped addresses read as zero
                            if (shift_in[6:0] == AUX_DAMP_ADDR) begin
                                tx_nxt = aux_r;
                            end else if (shift_in[6:0] == MAIN_DAMP_ADDR) begin
                                tx_nxt = main_r;
                            end else begin
                                tx_nxt = 8'h00;
                            end
                        end
                    end
                end
                SP_DATA: begin
                    if (sclk_rise) begin
                        rx_nxt  = shift_in;
                        cnt_nxt = cnt_r + 3'h1;
                        // Shift after master sampled on the same edge
                        tx_nxt  = {tx_r[6:0], 1'b0};
                        if (cnt_r == LAST_BIT) begin
                            state_nxt = SP_DONE;
                            if (!cmd_r[CMD_RW_BIT]) begin
                                // Reserved bits never stored, read back zero
                                if (cmd_r[6:0] == AUX_DAMP_ADDR) begin
                                    aux_nxt = shift_in & DAMP_WRITE_MASK;
                                end else if (cmd_r[6:0] == MAIN_DAMP_ADDR) begin
                                    main_nxt = shift_in & DAMP_WRITE_MASK;
                                end
                            end
                        end
                    end
                end
                SP_DONE: begin
                    // Extra clocks ignored until chip select rises
                    state_nxt = SP_DONE;
                end
                default: begin
                    state_nxt = SP_IDLE;
                end
            endcase
        end
        oe_nxt = cs_active && (state_nxt == SP_DATA) && cmd_nxt[CMD_RW_BIT];
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            state_r      <= SP_IDLE;
            cnt_r        <= 3'h0;
            rx_r         <= 8'h00;
            cmd_r        <= 8'h00;
            tx_r         <= 8'h00;
            aux_r        <= AUX_DAMP_RESET;
            main_r       <= MAIN_DAMP_RESET;
            O_SPI_SDO_OE <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            cnt_r        <= cnt_nxt;
            rx_r         <= rx_nxt;
            cmd_r        <= cmd_nxt;
            tx_r         <= tx_nxt;
            aux_r        <= aux_nxt;
            main_r       <= main_nxt;
            O_SPI_SDO_OE <= oe_nxt;
        end
    end

    assign O_SPI_SDO = tx_r[7];

    // ****************************************************************
    // Loop settings
    // ****************************************************************
    logic [2:0] main_df_nxt;
    logic [2:0] aux_df_nxt;
    logic [2:0] main_g_nxt;
    logic [2:0] aux_g_nxt;
    logic       main_used_nxt;
    logic       aux_used_nxt;

    always_comb begin
        main_df_nxt   = damp_factor(main_r[CODE_MSB:CODE_LSB], I_MAIN_BW_CLASS);
        aux_df_nxt    = damp_factor(aux_r[CODE_MSB:CODE_LSB], I_AUX_BW_CLASS);
        main_used_nxt = I_MAIN_GAIN_ON;
        aux_used_nxt  = I_AUX_GAIN_ON;
        main_g_nxt    = 3'h0;
        aux_g_nxt     = 3'h0;
        if (I_MAIN_GAIN_ON) begin
            main_g_nxt = spd_gain(I_MAIN_ANALOG, I_MAIN_REF_LE_8K,
                                  main_r[GAIN_MSB:GAIN_LSB], I_MAIN_HF_GAIN);
        end
        if (I_AUX_GAIN_ON) begin
            aux_g_nxt = spd_gain(I_AUX_ANALOG, I_AUX_REF_LE_8K,
                                 aux_r[GAIN_MSB:GAIN_LSB], I_AUX_HF_GAIN);
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_MAIN_DAMP_FACTOR <= DF_5;
            O_AUX_DAMP_FACTOR  <= DF_5;
            O_MAIN_SPD_USED    <= 1'b0;
            O_AUX_SPD_USED     <= 1'b0;
            O_MAIN_SPD_GAIN    <= 3'h0;
            O_AUX_SPD_GAIN     <= 3'h0;
        end else begin
            O_MAIN_DAMP_FACTOR <= main_df_nxt;
            O_AUX_DAMP_FACTOR  <= aux_df_nxt;
            O_MAIN_SPD_USED    <= main_used_nxt;
            O_AUX_SPD_USED     <= aux_used_nxt;
            O_MAIN_SPD_GAIN    <= main_g_nxt;
            O_AUX_SPD_GAIN     <= aux_g_nxt;
        end
    end

endmodule

// >>> damp_cfg_monitor.sv
`timescale 1ns/1ps
module damp_cfg_monitor
    import damp_cfg_pkg::*;
(
    input wire logic       I_CLK,
    input wire logic       I_SYS_RST,
    input wire logic       I_SPI_CS_N,
    input wire logic       O_SPI_SDO_OE,
    input wire logic [2:0] I_MAIN_BW_CLASS,
    input wire logic [2:0] I_AUX_BW_CLASS,
    input wire logic       I_MAIN_GAIN_ON,
    input wire logic       I_AUX_GAIN_ON,
    input wire logic [2:0] I_MAIN_HF_GAIN,
    input wire logic       I_MAIN_ANALOG,
    input wire logic       I_MAIN_REF_LE_8K,
    input wire logic [2:0] O_MAIN_DAMP_FACTOR,
    input wire logic [2:0] O_AUX_DAMP_FACTOR,
    input wire logic       O_MAIN_SPD_USED,
    input wire logic [2:0] O_MAIN_SPD_GAIN,
    input wire logic [2:0] O_AUX_SPD_GAIN
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_used;
        !$past(I_SYS_RST) |-> O_MAIN_SPD_USED == $past(I_MAIN_GAIN_ON);
    endproperty
    a_used: assert property (p_used) else $error("gain enable delay wrong");
    property p_off;
        !$past(I_SYS_RST) && !$past(I_AUX_GAIN_ON) |-> O_AUX_SPD_GAIN == 3'h0;
    endproperty
    a_off: assert property (p_off) else $error("aux gain while disabled");
    property p_gain_used;
        O_MAIN_SPD_GAIN != 3'h0 |-> O_MAIN_SPD_USED;
    endproperty
    a_gain_used: assert property (p_gain_used) else $error("gain without use");
    property p_hf;
        !$past(I_SYS_RST) && $past(I_MAIN_GAIN_ON)
            && !($past(I_MAIN_ANALOG) && $past(I_MAIN_REF_LE_8K))
            |-> O_MAIN_SPD_GAIN == $past(I_MAIN_HF_GAIN);
    endproperty
    a_hf: assert property (p_hf) else $error("high band gain not taken");
    property p_bad_bw;
        !$past(I_SYS_RST) && $past(I_MAIN_BW_CLASS) > BW_70HZ |-> O_MAIN_DAMP_FACTOR == DF_NONE;
    endproperty
    a_bad_bw: assert property (p_bad_bw) else $error("bad class gave factor");
    property p_slow;
        !$past(I_SYS_RST) && $past(I_AUX_BW_CLASS) == BW_4HZ && O_AUX_DAMP_FACTOR != DF_NONE
            |-> O_AUX_DAMP_FACTOR == DF_5;
    endproperty
    a_slow: assert property (p_slow) else $error("slow class factor wrong");
    property p_rst;
        $fell(I_SYS_RST) |-> O_MAIN_DAMP_FACTOR == DF_5 ##1 O_MAIN_DAMP_FACTOR == DF_5;
    endproperty
    a_rst: assert property (p_rst) else $error("reset factor wrong");
    // Six clocks cover the chip-select synchroniser
    property p_oe;
        I_SPI_CS_N [*6] |-> !O_SPI_SDO_OE;
    endproperty
    a_oe: assert property (p_oe) else $error("data out driven while idle");
    c_gain: cover property (O_MAIN_SPD_GAIN != 3'h0);
    c_read: cover property (O_SPI_SDO_OE);
    c_bad: cover property ($past(I_MAIN_BW_CLASS) > BW_70HZ);
endmodule
bind damp_cfg damp_cfg_monitor u_mon (.*);

// >>> damp_cfg_test.sv
`timescale 1ns/1ps
module damp_cfg_test;
    import damp_cfg_pkg::*;
    logic       clk, rst, cs_n, sclk, sdi, sdo, sdo_oe, gon, ana, le8, used_m, used_a;
    logic [2:0] bw, bw_a, hf_m, hf_a, fac_m, fac_a, g_m, g_a;
    logic [7:0] rd;
    int         err_total, num_checks;
    localparam logic [2:0] TBL [5][5] = '{'{DF_5, DF_2P5, DF_1P2, DF_1P2, DF_1P2},
        '{DF_5, DF_5, DF_2P5, DF_2P5, DF_2P5}, '{5{DF_5}},
        '{DF_5, DF_10, DF_10, DF_10, DF_10}, '{DF_5, DF_10, DF_20, DF_20, DF_20}};
    damp_cfg uut (.I_CLK(clk), .I_SYS_RST(rst), .I_SPI_CS_N(cs_n), .I_SPI_SCLK(sclk),
        .I_SPI_SDI(sdi), .O_SPI_SDO(sdo), .O_SPI_SDO_OE(sdo_oe), .I_MAIN_BW_CLASS(bw),
        .I_AUX_BW_CLASS(bw_a), .I_MAIN_GAIN_ON(gon), .I_AUX_GAIN_ON(gon),
        .I_MAIN_HF_GAIN(hf_m), .I_AUX_HF_GAIN(hf_a), .I_MAIN_ANALOG(ana), .I_AUX_ANALOG(ana),
        .I_MAIN_REF_LE_8K(le8), .I_AUX_REF_LE_8K(le8), .O_MAIN_DAMP_FACTOR(fac_m),
        .O_AUX_DAMP_FACTOR(fac_a), .O_MAIN_SPD_USED(used_m), .O_AUX_SPD_USED(used_a),
        .O_MAIN_SPD_GAIN(g_m), .O_AUX_SPD_GAIN(g_a));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Half periods of 5 clocks clear the 4-clock minimum plus synchroniser lag
    task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] w);
        logic [15:0] sh;
        sh = {r, a, w};
        cs_n = 0;
        tick(5);
        for (int i = 15; i >= 0; i--) begin
            sdi = sh[i];
            tick(5);
            if (i < 8) rd[i] = sdo_oe ? sdo : 1'bx;
            sclk = 1;
            tick(5);
            sclk = 0;
        end
        tick(6);
        cs_n = 1;
        tick(6);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200us;
        err_total++;
        $display("FAIL %0t timeout", $time);
        finish_test();
    end
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        {rst, cs_n, sclk, sdi, gon, ana, le8} = 7'b1100000;
        {bw, bw_a, hf_m, hf_a} = {BW_4HZ, BW_4HZ, 3'h2, 3'h3};
        err_total = 0;
        num_checks = 0;
        tick(3);
        rst = 0;
        tick(4);
        xfer(1, AUX_DAMP_ADDR, 8'h00);
        chk(rd, 8'h13, "aux reset");
        xfer(1, MAIN_DAMP_ADDR, 8'h00);
        chk(rd, 8'h13, "main reset");
        chk({2'b00, fac_m, fac_a}, {2'b00, DF_5, DF_5}, "default factor");
        $display("reset test done");
        for (int c = 1; c <= 5; c++) begin
            xfer(0, MAIN_DAMP_ADDR, 8'(c));
            xfer(0, AUX_DAMP_ADDR, 8'(c));
            for (int b = 0; b <= 5; b++) begin
                bw = 3'(b);
                bw_a = 3'(b);
                tick(2);
                chk(8'(fac_m), 8'(b > 4 ? DF_NONE : TBL[c-1][b]), "main factor");
                chk(8'(fac_a), 8'(b > 4 ? DF_NONE : TBL[c-1][b]), "aux factor");
            end
        end
        $display("table test done");
        {bw, bw_a} = {BW_8HZ, BW_8HZ};
        xfer(0, MAIN_DAMP_ADDR, 8'hFF);
        xfer(1, MAIN_DAMP_ADDR, 8'h00);
        chk(rd, 8'h77, "reserved bits");
        chk(8'(fac_m), 8'(DF_NONE), "unused code");
        xfer(0, 7'h10, 8'h5A);
        xfer(1, 7'h10, 8'h00);
        chk(rd, 8'h00, "unmapped read");
        $display("reserved test done");
        xfer(0, MAIN_DAMP_ADDR, 8'h53);
        xfer(0, AUX_DAMP_ADDR, 8'h63);
        {gon, ana, le8} = 3'b111;
        tick(2);
        chk({g_m, g_a, used_m, used_a}, {3'h5, 3'h6, 2'b11}, "low band gain");
        le8 = 0;
        tick(2);
        chk({g_m, g_a, 2'b00}, {hf_m, hf_a, 2'b00}, "high band gain");
        {ana, le8} = 2'b01;
        tick(2);
        chk({g_m, g_a, 2'b00}, {hf_m, hf_a, 2'b00}, "digital mode gain");
        {gon, le8} = 2'b01;
        tick(2);
        chk({g_m, g_a, used_m, used_a}, 8'h00, "gain disabled");
        $display("gain test done");
        rst = 1;
        tick(3);
        rst = 0;
        tick(4);
        xfer(1, MAIN_DAMP_ADDR, 8'h00);
        chk(rd, MAIN_DAMP_RESET, "main after second reset");
        xfer(1, AUX_DAMP_ADDR, 8'h00);
        chk(rd, AUX_DAMP_RESET, "aux after second reset");
        $display("second reset test done");
        finish_test();
    end
endmodule
